// >>> shared/dcsf_params.svh
// dcsf_params.svh - widths, depth, reset values of one first-in first-out channel.
// assumes inclusion by bare name from the package and the design modules.
`ifndef DCSF_PARAMS_SVH
`define DCSF_PARAMS_SVH

// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define DCSF_DATA_W      18
`define DCSF_ADDR_W      8
`define DCSF_CNT_W       9
`define DCSF_OFF_W       12
`define DCSF_DEPTH       9'h100
`define DCSF_HALF        9'h080
`define DCSF_LAST_ADDR   8'hFF

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DCSF_OFFSET_RST  12'h01F
`define DCSF_STRAP_STD_SYNC   3'h0
`define DCSF_STRAP_STD_ASYNC  3'h2
`define DCSF_STRAP_FALL_SYNC  3'h4
`define DCSF_STRAP_FALL_ASYNC 3'h6
// any code outside the four above selects chain mode; this one heads the chain
`define DCSF_STRAP_CHAIN_HEAD 3'h3

`endif

// >>> shared/dcsf_pkg.sv
// dcsf_pkg - types shared by the channel and its offset register block.
// assumes dcsf_params.svh on the include path.
`include "dcsf_params.svh"

package dcsf_pkg;

  // ----------------------------------------------------------------------------
  // operating mode caught from the straps during reset
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic fall_thru;
    logic async_flags;
    logic chained;
  } dcsf_mode_type;

  // which offset register the load sequence addresses next
  typedef enum logic [0:0] {
    DCSF_SEL_EMPTY = 1'b0,
    DCSF_SEL_FULL  = 1'b1
  } dcsf_sel_type;

endpackage : dcsf_pkg

// >>> core/dcsf_offset_regs.sv
// dcsf_offset_regs - almost-empty and almost-full offset registers, loaded
// and read back in turn through the data pins.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "dcsf_params.svh"

module dcsf_offset_regs (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   load_wr_in,
  input  wire logic                   load_rd_in,
  input  wire logic [`DCSF_OFF_W-1:0] load_data_in,
  output logic      [`DCSF_OFF_W-1:0] empty_off_out,
  output logic      [`DCSF_OFF_W-1:0] full_off_out,
  output logic      [`DCSF_OFF_W-1:0] rd_data_out
);

  dcsf_pkg::dcsf_sel_type wr_sel_r;
  dcsf_pkg::dcsf_sel_type rd_sel_r;

  // ----------------------------------------------------------------------------
  // load sequence
  // ----------------------------------------------------------------------------
  // offsets loaded
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      empty_off_out <= `DCSF_OFFSET_RST;
      full_off_out  <= `DCSF_OFFSET_RST;
      wr_sel_r      <= dcsf_pkg::DCSF_SEL_EMPTY;
    end else if (load_wr_in) begin
      case (wr_sel_r)
        dcsf_pkg::DCSF_SEL_EMPTY: begin
          empty_off_out <= load_data_in;
          wr_sel_r      <= dcsf_pkg::DCSF_SEL_FULL;
        end
        dcsf_pkg::DCSF_SEL_FULL: begin
          full_off_out <= load_data_in;
          wr_sel_r     <= dcsf_pkg::DCSF_SEL_EMPTY;
        end
        default: wr_sel_r <= dcsf_pkg::DCSF_SEL_EMPTY;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // readback sequence, independent of the load sequence
  // ----------------------------------------------------------------------------
  // offsets read back
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_sel_r <= dcsf_pkg::DCSF_SEL_EMPTY;
    end else if (load_rd_in) begin
      case (rd_sel_r)
        dcsf_pkg::DCSF_SEL_EMPTY: rd_sel_r <= dcsf_pkg::DCSF_SEL_FULL;
        dcsf_pkg::DCSF_SEL_FULL:  rd_sel_r <= dcsf_pkg::DCSF_SEL_EMPTY;
        default:                  rd_sel_r <= dcsf_pkg::DCSF_SEL_EMPTY;
      endcase
    end
  end

  always_comb begin
    rd_data_out = (rd_sel_r == dcsf_pkg::DCSF_SEL_FULL) ? full_off_out : empty_off_out;
  end

endmodule : dcsf_offset_regs

// >>> core/dcsf_channel.sv
// dcsf_channel - one 18-bit first-in first-out channel with offset flags,
// standard or fall-through timing and daisy-chain depth expansion.
// assumes read and write ports share clk_in; all inputs synchronous to it.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "dcsf_params.svh"

// Functional notes
// - reset empties pointers; full and almost-full high, empty and almost-empty low
// - write enable low stores the input word when not full
// - write enable high leaves memory and write pointer alone
// - writes are ignored while the memory is full
// - read enable low moves the next word to the output register
// - read enable high keeps the output register unchanged in standard mode
// - reads are ignored while the memory is empty
// - output enable low drives the data bus, high releases it
// - load with write enable writes data bits 0-11 into offset registers
// - load with read enable shows offset registers on output bits 0-11
// - straps choose standard or fall-through and sync or async almost flags
// - full/ready pin is full flag in standard, input ready in fall-through
// - empty/ready pin is empty flag in standard, output ready in fall-through
// - almost-empty low within programmed offset of empty, default 31
// - almost-full low within programmed offset of full, default 31
// - single device: write chain-out pin is half-full, low above half; read chain-out pin stays high
// - chain: pulse out when last location written or read
// - fall-through: first word appears after three read clock edges
module dcsf_channel #(
  parameter logic [2:0] STD_SYNC_CODE   = `DCSF_STRAP_STD_SYNC,
  parameter logic [2:0] STD_ASYNC_CODE  = `DCSF_STRAP_STD_ASYNC,
  parameter logic [2:0] FALL_SYNC_CODE  = `DCSF_STRAP_FALL_SYNC,
  parameter logic [2:0] FALL_ASYNC_CODE = `DCSF_STRAP_FALL_ASYNC
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [`DCSF_DATA_W-1:0] data_in,
  input  wire logic                    write_enable_n_in,
  input  wire logic                    read_enable_n_in,
  input  wire logic                    output_enable_n_in,
  input  wire logic                    load_strobe_n_in,
  input  wire logic                    first_load_select_n_in,
  input  wire logic                    write_chain_n_in,
  input  wire logic                    read_chain_n_in,
  output logic      [`DCSF_DATA_W-1:0] data_out,
  output logic                         data_oe_out,
  output logic                         full_ready_out,
  output logic                         empty_ready_out,
  output logic                         almost_empty_n_out,
  output logic                         almost_full_n_out,
  output logic                         write_chain_n_out,
  output logic                         read_chain_n_out
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic [`DCSF_DATA_W-1:0] mem [0:`DCSF_DEPTH-1];

  dcsf_pkg::dcsf_mode_type mode_r;
  dcsf_pkg::dcsf_mode_type mode_dec;
  logic [2:0]              strap;

  logic [`DCSF_ADDR_W-1:0] wptr_r;
  logic [`DCSF_ADDR_W-1:0] rptr_r;
  logic [`DCSF_CNT_W-1:0]  count_r;
  logic [`DCSF_CNT_W-1:0]  count_nxt;
  logic [`DCSF_CNT_W-1:0]  level;
  logic                    out_valid_r;
  logic                    out_valid_nxt;
  logic                    avail_q1_r;
  logic                    avail_q2_r;
  logic                    wtok_r;
  logic                    rtok_r;

  logic                    load;
  logic                    wr_req;
  logic                    rd_req;
  logic                    wr_off;
  logic                    rd_off;
  logic                    wr_mem;
  logic                    rd_mem;
  logic                    pop_out;
  logic                    fetch;
  logic                    full_now;
  logic                    full_nxt;
  logic                    wr_last;
  logic                    rd_last;

  logic [`DCSF_OFF_W-1:0]  empty_off;
  logic [`DCSF_OFF_W-1:0]  full_off;
  logic [`DCSF_OFF_W-1:0]  off_rd_data;
  logic [`DCSF_OFF_W:0]    level_w;
  logic [`DCSF_OFF_W:0]    af_sum;

  // ----------------------------------------------------------------------------
  // mode straps
  // ----------------------------------------------------------------------------
  assign strap = {first_load_select_n_in, write_chain_n_in, read_chain_n_in};

  always_comb begin
    mode_dec = '{fall_thru: 1'b0, async_flags: 1'b0, chained: 1'b0};
    case (strap)
      STD_SYNC_CODE:   mode_dec = '{fall_thru: 1'b0, async_flags: 1'b0, chained: 1'b0};
      STD_ASYNC_CODE:  mode_dec = '{fall_thru: 1'b0, async_flags: 1'b1, chained: 1'b0};
      FALL_SYNC_CODE:  mode_dec = '{fall_thru: 1'b1, async_flags: 1'b0, chained: 1'b0};
      FALL_ASYNC_CODE: mode_dec = '{fall_thru: 1'b1, async_flags: 1'b1, chained: 1'b0};
      // any other code means the chain wiring is in place
      default:         mode_dec = '{fall_thru: 1'b0, async_flags: 1'b0, chained: 1'b1};
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_r <= mode_dec;
    end
  end

  // ----------------------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------------------
  assign load     = ~load_strobe_n_in;
  assign wr_req   = ~write_enable_n_in;
  assign rd_req   = ~read_enable_n_in;
  assign full_now = (count_r == `DCSF_DEPTH);
  assign wr_off   = wr_req & load;
  assign rd_off   = rd_req & load;
  assign wr_last  = (wptr_r == `DCSF_LAST_ADDR);
  assign rd_last  = (rptr_r == `DCSF_LAST_ADDR);

  // only the token holder of a chain accepts words
  assign wr_mem = wr_req & ~load & ~full_now & (~mode_r.chained | wtok_r);

  // fall-through keeps one word staged in the output register
  assign pop_out = out_valid_r & rd_req & ~load;

  // prefetch waits for the two-stage availability pipe
  assign fetch = (count_r != {`DCSF_CNT_W{1'b0}}) & avail_q2_r & ~rd_off &
                 (~out_valid_r | pop_out);

  always_comb begin
    if (mode_r.fall_thru) begin
      rd_mem = fetch;
    end else begin
      rd_mem = rd_req & ~load & (count_r != {`DCSF_CNT_W{1'b0}}) &
               (~mode_r.chained | rtok_r);
    end
  end

  always_comb begin
    count_nxt = count_r;
    if (wr_mem && !rd_mem) begin
      count_nxt = count_r + `DCSF_CNT_W'(1);
    end else if (rd_mem && !wr_mem) begin
      count_nxt = count_r - `DCSF_CNT_W'(1);
    end
  end

  always_comb begin
    out_valid_nxt = out_valid_r;
    if (rd_mem) begin
      out_valid_nxt = 1'b1;
    end else if (pop_out) begin
      out_valid_nxt = 1'b0;
    end
  end

  assign full_nxt = (count_nxt == `DCSF_DEPTH);

  // ----------------------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------------------
  // word store
  always_ff @(posedge clk_in) begin
    if (wr_mem) begin
      mem[wptr_r] <= data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wptr_r      <= {`DCSF_ADDR_W{1'b0}};
      rptr_r      <= {`DCSF_ADDR_W{1'b0}};
      count_r     <= {`DCSF_CNT_W{1'b0}};
      out_valid_r <= 1'b0;
    end else begin
      if (wr_mem) begin
        wptr_r <= wptr_r + `DCSF_ADDR_W'(1);
      end
      if (rd_mem) begin
        rptr_r <= rptr_r + `DCSF_ADDR_W'(1);
      end
      count_r     <= count_nxt;
      out_valid_r <= mode_r.fall_thru ? out_valid_nxt : 1'b0;
    end
  end

  // the pipe delays both rise and fall; the live count still guards each fetch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avail_q1_r <= 1'b0;
      avail_q2_r <= 1'b0;
    end else begin
      avail_q1_r <= (count_r != {`DCSF_CNT_W{1'b0}});
      avail_q2_r <= avail_q1_r;
    end
  end

  // ----------------------------------------------------------------------------
  // output register and bus enable
  // ----------------------------------------------------------------------------
  // output register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_out <= {`DCSF_DATA_W{1'b0}};
    end else if (rd_off) begin
      data_out <= {{(`DCSF_DATA_W-`DCSF_OFF_W){1'b0}}, off_rd_data};
    end else if (rd_mem) begin
      data_out <= mem[rptr_r];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= ~output_enable_n_in;
    end
  end

  // ----------------------------------------------------------------------------
  // offset registers
  // ----------------------------------------------------------------------------
  dcsf_offset_regs u_offset_regs (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .load_wr_in    (wr_off),
    .load_rd_in    (rd_off),
    .load_data_in  (data_in[`DCSF_OFF_W-1:0]),
    .empty_off_out (empty_off),
    .full_off_out  (full_off),
    .rd_data_out   (off_rd_data)
  );

  // ----------------------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------------------
  // shared pin meaning follows the mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      full_ready_out  <= 1'b1;
      empty_ready_out <= 1'b0;
    end else if (mode_r.fall_thru) begin
      full_ready_out  <= full_nxt;
      empty_ready_out <= ~out_valid_nxt;
    end else begin
      full_ready_out  <= ~full_nxt;
      empty_ready_out <= (count_nxt != {`DCSF_CNT_W{1'b0}});
    end
  end

  // async flags follow the new level at once, sync ones one edge later
  assign level   = mode_r.async_flags ? count_nxt : count_r;
  assign level_w = {{(`DCSF_OFF_W+1-`DCSF_CNT_W){1'b0}}, level};
  assign af_sum  = level_w + {1'b0, full_off};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      almost_empty_n_out <= 1'b0;
      almost_full_n_out  <= 1'b1;
    end else begin
      almost_empty_n_out <= ~(level_w <= {1'b0, empty_off});
      almost_full_n_out  <= ~(af_sum >= {{(`DCSF_OFF_W+1-`DCSF_CNT_W){1'b0}}, `DCSF_DEPTH});
    end
  end

  // ----------------------------------------------------------------------------
  // chain outputs and tokens
  // ----------------------------------------------------------------------------
  // chain-out pins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_chain_n_out <= 1'b1;
      read_chain_n_out  <= 1'b1;
    end else if (mode_r.chained) begin
      write_chain_n_out <= ~(wr_mem & wr_last);
      read_chain_n_out  <= ~(rd_mem & rd_last);
    end else begin
      write_chain_n_out <= ~(count_nxt > `DCSF_HALF);
      read_chain_n_out  <= 1'b1;
    end
  end

  // token passing; a token arriving wins over one leaving
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wtok_r <= ~first_load_select_n_in;
      rtok_r <= ~first_load_select_n_in;
    end else begin
      if (!write_chain_n_in) begin
        wtok_r <= 1'b1;
      end else if (wr_mem && wr_last) begin
        wtok_r <= 1'b0;
      end
      if (!read_chain_n_in) begin
        rtok_r <= 1'b1;
      end else if (rd_mem && rd_last) begin
        rtok_r <= 1'b0;
      end
    end
  end

endmodule : dcsf_channel

// >>> verification/dcsf_channel_properties.sv
// dcsf_channel_properties - pin-level timing checks on one channel.
// assumes a bind to dcsf_channel; straps are caught while rst_in is high.
`timescale 1ns/10ps
`include "dcsf_params.svh"

module dcsf_channel_properties (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        write_enable_n_in,
  input wire logic        read_enable_n_in,
  input wire logic        output_enable_n_in,
  input wire logic        load_strobe_n_in,
  input wire logic        first_load_select_n_in,
  input wire logic        write_chain_n_in,
  input wire logic        read_chain_n_in,
  input wire logic [17:0] data_out,
  input wire logic        data_oe_out,
  input wire logic        full_ready_out,
  input wire logic        empty_ready_out,
  input wire logic        almost_empty_n_out,
  input wire logic        almost_full_n_out,
  input wire logic        write_chain_n_out,
  input wire logic        read_chain_n_out
);
  logic [2:0] strap_r;
  logic       std_w;
  logic       fall_w;
  logic       wr_w;

  // ---------------------------------------------------------------------------
  // mode tracking
  // ---------------------------------------------------------------------------
  // straps held from reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      strap_r <= {first_load_select_n_in, write_chain_n_in, read_chain_n_in};
    end
  end
  assign std_w  = (strap_r == `DCSF_STRAP_STD_SYNC) || (strap_r == `DCSF_STRAP_STD_ASYNC);
  assign fall_w = (strap_r == `DCSF_STRAP_FALL_SYNC) || (strap_r == `DCSF_STRAP_FALL_ASYNC);
  assign wr_w   = !write_enable_n_in && load_strobe_n_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence first_word_s;
    write_enable_n_in [*3] ##1 (fall_w && wr_w && empty_ready_out);
  endsequence
  sequence fall_s;
    ##3 empty_ready_out ##1 !empty_ready_out;
  endsequence

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  reset_flags_a: assert property (disable iff (1'b0) rst_in |=> full_ready_out
    && !empty_ready_out && !almost_empty_n_out && almost_full_n_out && write_chain_n_out
    && read_chain_n_out) else $error("flags wrong during reset");
  oe_follow_a: assert property ($past(!rst_in) |-> data_oe_out == !$past(output_enable_n_in))
    else $error("bus enable does not follow output enable");
  hold_no_read_a: assert property (std_w && read_enable_n_in |=> $stable(data_out))
    else $error("output word changed without a read");
  read_empty_a: assert property (std_w && !read_enable_n_in && load_strobe_n_in
    && !empty_ready_out |=> $stable(data_out)) else $error("read taken while empty");
  write_fills_a: assert property (std_w && wr_w && full_ready_out && read_enable_n_in
    |=> empty_ready_out) else $error("write did not clear empty");
  full_refuse_a: assert property (std_w && wr_w && !full_ready_out && read_enable_n_in
    |=> !full_ready_out) else $error("write while full changed the fill");
  full_flags_a: assert property (std_w && !full_ready_out |->
    !almost_full_n_out && !write_chain_n_out) else $error("full without almost and half");
  empty_flags_a: assert property (std_w && !empty_ready_out |-> !almost_empty_n_out)
    else $error("empty without almost empty");
  fall_three_a: assert property (first_word_s |-> fall_s)
    else $error("first word did not fall through on the third edge");
endmodule : dcsf_channel_properties

// >>> verification/dcsf_consumer.sv
// dcsf_consumer - read-side partner: pop request to active-low read enable,
// and the three-state data bus as the consumer sees it.
// assumes pop_in changes just after a rising edge.
`timescale 1ns/10ps

module dcsf_consumer (
  input  wire logic        clk_in,
  input  wire logic        pop_in,
  input  wire logic        oe_in,
  input  wire logic [17:0] data_in,
  output logic             read_enable_n_out,
  output logic      [17:0] bus_out
);
  logic [17:0] last_r;

  // ---------------------------------------------------------------------------
  // bus resolution
  // ---------------------------------------------------------------------------
  assign read_enable_n_out = ~pop_in;
  // released bus floats
  // a floating bus must never pass for the last word, so its inverse shows
  assign bus_out = oe_in ? data_in : ~last_r;

  always_ff @(posedge clk_in) begin
    if (oe_in) begin
      last_r <= data_in;
    end
  end
endmodule : dcsf_consumer

// >>> verification/dcsf_channel_tb.sv
// dcsf_channel_tb - self-checking bench, channel against a queue model.
// assumes the checker and consumer files are compiled before this one.
`timescale 1ns/10ps
`include "dcsf_params.svh"

bind dcsf_channel dcsf_channel_properties i_props (
  .clk_in(clk_in), .rst_in(rst_in), .write_enable_n_in(write_enable_n_in),
  .read_enable_n_in(read_enable_n_in), .output_enable_n_in(output_enable_n_in),
  .load_strobe_n_in(load_strobe_n_in), .first_load_select_n_in(first_load_select_n_in),
  .write_chain_n_in(write_chain_n_in), .read_chain_n_in(read_chain_n_in),
  .data_out(data_out), .data_oe_out(data_oe_out), .full_ready_out(full_ready_out),
  .empty_ready_out(empty_ready_out), .almost_empty_n_out(almost_empty_n_out),
  .almost_full_n_out(almost_full_n_out), .write_chain_n_out(write_chain_n_out),
  .read_chain_n_out(read_chain_n_out));

module dcsf_channel_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [17:0] din    = 18'h00000;
  logic        wen_n  = 1'b1;
  logic        pop    = 1'b0;
  logic        oe_n   = 1'b0;
  logic        load_n = 1'b1;
  logic [2:0]  strap  = 3'h0;
  logic [31:0] lfsr_r = 32'h5755;
  logic [17:0] dout, bus, last;
  logic        ren_n, data_oe, full_rdy, empty_rdy, ae_n, af_n, wchain_n, rchain_n;
  logic [17:0] q[$];
  int          error_cnt, tests_run, eoff, foff;

  always #4 clk_in = ~clk_in;

  dcsf_channel i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .data_in(din), .write_enable_n_in(wen_n),
    .read_enable_n_in(ren_n), .output_enable_n_in(oe_n), .load_strobe_n_in(load_n),
    .first_load_select_n_in(strap[2]), .write_chain_n_in(strap[1]),
    .read_chain_n_in(strap[0]), .data_out(dout), .data_oe_out(data_oe),
    .full_ready_out(full_rdy), .empty_ready_out(empty_rdy), .almost_empty_n_out(ae_n),
    .almost_full_n_out(af_n), .write_chain_n_out(wchain_n), .read_chain_n_out(rchain_n));
  dcsf_consumer i_cons (.clk_in(clk_in), .pop_in(pop), .oe_in(data_oe), .data_in(dout),
    .read_enable_n_out(ren_n), .bus_out(bus));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic drive(input logic w, input logic r, input logic cfg, input logic [17:0] d);
    @(posedge clk_in);
    wen_n  <= ~w;
    pop    <= r;
    load_n <= ~cfg;
    din   <= d;
  endtask : drive

  task automatic wr(input int n);
    repeat (n) begin
      lfsr_r = lfsr_next(lfsr_r);
      drive(1'b1, 1'b0, 1'b0, lfsr_r[17:0]);
      if (q.size() < `DCSF_DEPTH) q.push_back(lfsr_r[17:0]);
    end
    drive(1'b0, 1'b0, 1'b0, 18'h3FFFF);
  endtask : wr

  task automatic rd_chk(input logic cfg, input logic [17:0] e);
    if (cfg) last = e;
    else if (q.size() > 0) last = q.pop_front();
    drive(1'b0, 1'b1, cfg, 18'h00000);
    drive(1'b0, 1'b0, 1'b0, 18'h00000);
    #1;
    chk(bus, last);
  endtask : rd_chk

  task automatic flags();
    int n;
    n = q.size();
    repeat (3) drive(1'b0, 1'b0, 1'b0, 18'h00000);
    #1;
    chk({17'h0, full_rdy}, {17'h0, n != `DCSF_DEPTH});
    chk({17'h0, empty_rdy}, {17'h0, n != 0});
    chk({17'h0, ae_n}, {17'h0, n > eoff});
    chk({17'h0, af_n}, {17'h0, n + foff < `DCSF_DEPTH});
    chk({17'h0, wchain_n}, {17'h0, n <= `DCSF_HALF});
  endtask : flags

  task automatic reset_dut(input logic [2:0] s);
    @(posedge clk_in);
    rst_in <= 1'b1;
    strap  <= s;
    repeat (4) @(posedge clk_in);
    #1;
    chk({12'h0, full_rdy, empty_rdy, ae_n, af_n, wchain_n, rchain_n}, 18'h00027);
    chk({dout[16:0], data_oe}, 18'h00000);
    @(posedge clk_in);
    rst_in <= 1'b0;
    q.delete();
    eoff = `DCSF_OFFSET_RST;
    foff = `DCSF_OFFSET_RST;
  endtask : reset_dut

  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end

  initial begin
    reset_dut(`DCSF_STRAP_STD_SYNC);
    // one word past full must be dropped
    wr(100);
    flags();
    wr(157);
    flags();
    for (int i = 0; i < 256; i++) begin
      rd_chk(1'b0, 18'h00000);
      if (i % 64 == 0) flags();
    end
    rd_chk(1'b0, 18'h00000);
    flags();
    $display("test fill and drain done");
    reset_dut(`DCSF_STRAP_STD_ASYNC);
    drive(1'b1, 1'b0, 1'b1, 18'h3F005);
    drive(1'b1, 1'b0, 1'b1, 18'h2A00A);
    eoff = 5;
    foff = 10;
    rd_chk(1'b1, 18'h00005);
    rd_chk(1'b1, 18'h0000A);
    wr(5);
    flags();
    wr(1);
    flags();
    repeat (6) rd_chk(1'b0, 18'h00000);
    $display("test offsets done");
    @(posedge clk_in);
    oe_n <= 1'b1;
    drive(1'b0, 1'b0, 1'b0, 18'h00000);
    #1;
    chk({17'h0, data_oe}, 18'h00000);
    @(posedge clk_in);
    oe_n <= 1'b0;
    drive(1'b0, 1'b0, 1'b0, 18'h00000);
    #1;
    chk({17'h0, data_oe}, 18'h00001);
    $display("test output enable done");
    for (int m = 0; m < 2; m++) begin
      reset_dut(m ? `DCSF_STRAP_FALL_ASYNC : `DCSF_STRAP_FALL_SYNC);
      repeat (4) drive(1'b0, 1'b0, 1'b0, 18'h00000);
      #1;
      chk({16'h0, full_rdy, empty_rdy}, 18'h00001);
      drive(1'b1, 1'b0, 1'b0, 18'h2D3C1);
      repeat (3) drive(1'b0, 1'b0, 1'b0, 18'h00000);
      #1;
      chk({17'h0, empty_rdy}, 18'h00001);
      drive(1'b0, 1'b0, 1'b0, 18'h00000);
      #1;
      chk({17'h0, empty_rdy}, 18'h00000);
      chk(bus, 18'h2D3C1);
      $display("test fall-through done");
    end
    // first device of a chain: first load low, idle chain inputs high
    reset_dut(`DCSF_STRAP_CHAIN_HEAD);
    wr(255);
    drive(1'b1, 1'b0, 1'b0, 18'h15A5A);
    q.push_back(18'h15A5A);
    drive(1'b0, 1'b0, 1'b0, 18'h00000);
    #1;
    chk({17'h0, wchain_n}, 18'h00000);
    repeat (256) rd_chk(1'b0, 18'h00000);
    chk({17'h0, rchain_n}, 18'h00000);
    // the write token has gone on down the chain, so this word is refused
    drive(1'b1, 1'b0, 1'b0, 18'h00C3A);
    repeat (3) drive(1'b0, 1'b0, 1'b0, 18'h00000);
    #1;
    chk({17'h0, empty_rdy}, 18'h00000);
    $display("test chain done");
    conclude();
  end
endmodule : dcsf_channel_tb
